//--- core/conv_ctrl_consts.svh
// Register offsets, field positions and reset values of the converter control block.
//
// Function
// [R1] Eighteen selectable channels, indices zero to seventeen.
// [R2] First converter: sensor on sixteen, reference seventeen.
// [R3] Third converter: only 0-3, 10-13 external.
// [R4] Preempted trigger suspends ordinary, then ordinary resumes.
// [R5] Ordinary trigger waits for running preempted group.
// [R6] Slots take any channel; length fields count.
// [R7] Software enables sensor and waits before converting.
// [R8] Software keeps converter clock below 28 MHz.
// [R9] Software waits stabilisation time after power enable.
// [R10] Clearing power enable aborts, resets, powers down.
// [R11] Calibration start bit cleared by hardware when done.
// [R12] Calibration result stored and fed back to converter.
// [R13] Calibration result sets no flag, no DMA.
// [R14] Enabled hardware trigger starts only on rising edge.
// [R15] Software trigger bit starts group when selected.
// [R16] Rewriting set power enable triggers ordinary conversion.
// [R17] Four-bit select: 0111 software, 1000-1100 reserved.
// [R18] Ordinary code 0110: pin line or timer via mux.
// [R19] Preempted code 0110: pin line or timer via mux.
// [R20] Third converter has own timer mapping, same codes.
// [R21] Second converter issues no DMA requests.
// [R22] Reserved select codes never start a conversion.
`ifndef CONV_CTRL_CONSTS_SVH
`define CONV_CTRL_CONSTS_SVH

`define OFS_CTRL 12'h000
`define OFS_ORD_SEQ 12'h004
`define OFS_PRE_SEQ 12'h008
`define OFS_ORD_RESULT 12'h00C
`define OFS_PRE_RESULT 12'h010
`define OFS_STATUS 12'h014

`define CTRL_POWER 0
`define CTRL_CAL 1
`define CTRL_SENSOR 2
`define CTRL_ORD_TEN 3
`define CTRL_PRE_TEN 4
`define CTRL_ORD_SWT 5
`define CTRL_PRE_SWT 6
`define CTRL_DMA_EN 7
`define CTRL_ORD_SEL_LSB 8
`define CTRL_PRE_SEL_LSB 12
`define CTRL_ORD_MUX 16
`define CTRL_PRE_MUX 17

`define SEQ_LEN_LSB 20
`define SLOT_W 5

`define ST_ORD_END 0
`define ST_PRE_END 1
`define ST_ORD_BUSY 2
`define ST_PRE_BUSY 3
`define ST_CAL_BUSY 4

`define SEL_SOFT 4'h7
`define SEL_MUXED 4'h6
`define SEL_RSV_LO 4'h8
`define SEL_RSV_HI 4'hC
`define LAST_CHANNEL 5'h11
`define SENSOR_CHANNEL 5'h10

`define CTRL_RESET 32'h0000_0000
`define SEQ_RESET 32'h0000_0000

`endif

//--- core/conv_ctrl_pkg.sv
// Types shared by the converter control block.
package conv_ctrl_pkg;

    typedef struct packed {
        logic [15:0] timer_evt;
        logic ext_line;
    } trig_in_t;

    typedef struct packed {
        logic power_on;
        logic sensor_on;
        logic start;
        logic abort;
        logic calibrate;
        logic grounded;
        logic [4:0] channel;
    } conv_req_t;

    typedef struct packed {
        logic done;
        logic [11:0] data;
    } conv_rsp_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_IDLE,
        ST_CAL,
        ST_ORD,
        ST_PRE
    } seq_state_t;

endpackage

//--- core/conv_ctrl.sv
// Converter control: register file, trigger selection, group priority and calibration.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.svh"

module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int CONV_INDEX = 0,
    parameter int SLOTS = 4
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger sources.
    input wire trig_in_t ord_trig,
    input wire trig_in_t pre_trig,
    // Analog converter.
    output conv_req_t conv_req,
    input wire conv_rsp_t conv_rsp,
    output logic [11:0] cal_coeff,
    // DMA request.
    output logic dma_req
);

    localparam int IW = $clog2(SLOTS);

    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] oseq_r, oseq_nxt;
    logic [31:0] pseq_r, pseq_nxt;
    logic [11:0] ores_r, ores_nxt;
    logic [11:0] pres_r, pres_nxt;
    logic oend_r, oend_nxt;
    logic pend_flag_r, pend_flag_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [11:0] coeff_r, coeff_nxt;
    logic dma_r, dma_nxt;
    seq_state_t st_r, st_nxt;
    logic [IW-1:0] oidx_r, oidx_nxt;
    logic [IW-1:0] pidx_r, pidx_nxt;
    logic ord_wait_r, ord_wait_nxt;
    logic susp_r, susp_nxt;
    logic issued_r, issued_nxt;
    logic osrc_prev_r, osrc_prev_nxt;
    logic psrc_prev_r, psrc_prev_nxt;

    logic wr, rd, mapped;
    logic wr_ctrl;
    logic [3:0] osel, psel_code;
    logic osrc, psrc;
    logic ovalid, pvalid;
    logic o_hw_rise, p_hw_rise;
    logic o_go, p_go;
    logic o_last, p_last;
    logic [4:0] slot_ch;
    logic cal_busy;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign wr_ctrl = wr && (paddr == `OFS_CTRL);
    assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_ORD_SEQ) ||
                    (paddr == `OFS_PRE_SEQ) || (paddr == `OFS_ORD_RESULT) ||
                    (paddr == `OFS_PRE_RESULT) || (paddr == `OFS_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    assign osel = ctrl_r[`CTRL_ORD_SEL_LSB +: 4];
    assign psel_code = ctrl_r[`CTRL_PRE_SEL_LSB +: 4];
    assign cal_busy = ctrl_r[`CTRL_CAL];

    // Code 0110 on the first two converters goes through the pin/timer mux.
    always_comb begin
        osrc = ord_trig.timer_evt[osel];
        psrc = pre_trig.timer_evt[psel_code];
        if (CONV_INDEX != 2 && osel == `SEL_MUXED && !ctrl_r[`CTRL_ORD_MUX]) begin // R18 R20
            osrc = ord_trig.ext_line;
        end
        if (CONV_INDEX != 2 && psel_code == `SEL_MUXED && !ctrl_r[`CTRL_PRE_MUX]) begin // R19 R20
            psrc = pre_trig.ext_line;
        end
    end

    // Reserved and software codes never produce a hardware edge.
    assign ovalid = (osel != `SEL_SOFT) && !(osel >= `SEL_RSV_LO && osel <= `SEL_RSV_HI); // R17 R22
    assign pvalid = (psel_code != `SEL_SOFT) &&
                    !(psel_code >= `SEL_RSV_LO && psel_code <= `SEL_RSV_HI); // R17 R22
    assign o_hw_rise = ctrl_r[`CTRL_ORD_TEN] && ovalid && osrc && !osrc_prev_r; // R14
    assign p_hw_rise = ctrl_r[`CTRL_PRE_TEN] && pvalid && psrc && !psrc_prev_r; // R14

    // A rewrite of an already set power bit is an ordinary trigger on its own.
    assign o_go = o_hw_rise ||
        (wr_ctrl && pwdata[`CTRL_ORD_SWT] && osel == `SEL_SOFT && ctrl_r[`CTRL_ORD_TEN]) || // R15
        (wr_ctrl && pwdata[`CTRL_POWER] && ctrl_r[`CTRL_POWER]); // R16
    assign p_go = p_hw_rise ||
        (wr_ctrl && pwdata[`CTRL_PRE_SWT] && psel_code == `SEL_SOFT && ctrl_r[`CTRL_PRE_TEN]); // R15

    assign o_last = ({1'b0, oidx_r} == oseq_r[`SEQ_LEN_LSB +: IW + 1]); // R6
    assign p_last = ({1'b0, pidx_r} == pseq_r[`SEQ_LEN_LSB +: IW + 1]); // R6

    always_comb begin
        slot_ch = oseq_r[`SLOT_W * oidx_r +: `SLOT_W]; // R6
        if (st_r == ST_PRE) begin
            slot_ch = pseq_r[`SLOT_W * pidx_r +: `SLOT_W]; // R6
        end
    end

    // Channel map: indices outside the wired inputs are tied to analog ground.
    function automatic logic grounded_ch(input logic [4:0] ch);
        logic g;
        g = (ch > `LAST_CHANNEL); // R1
        if (CONV_INDEX == 1 && ch >= `SENSOR_CHANNEL) begin
            g = 1'b1;
        end
        if (CONV_INDEX == 2) begin // R3
            g = !(ch <= 5'h03 || (ch >= 5'h0A && ch <= 5'h0D));
        end
        return g;
    endfunction

    always_comb begin
        conv_req.power_on = ctrl_r[`CTRL_POWER]; // R10
        conv_req.sensor_on = ctrl_r[`CTRL_SENSOR] && (CONV_INDEX == 0); // R2
        conv_req.start = (st_r == ST_ORD || st_r == ST_PRE) && !issued_r;
        conv_req.calibrate = (st_r == ST_CAL) && !issued_r;
        conv_req.abort = (st_r == ST_ORD && p_go && issued_r) ||
                         (wr_ctrl && !pwdata[`CTRL_POWER] && st_r != ST_OFF); // R4 R10
        conv_req.channel = slot_ch;
        conv_req.grounded = grounded_ch(slot_ch); // R1 R2 R3
    end

    assign cal_coeff = coeff_r;
    assign dma_req = dma_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        oseq_nxt = oseq_r;
        pseq_nxt = pseq_r;
        ores_nxt = ores_r;
        pres_nxt = pres_r;
        oend_nxt = oend_r;
        pend_flag_nxt = pend_flag_r;
        prdata_nxt = prdata_r;
        coeff_nxt = coeff_r;
        dma_nxt = 1'b0;
        st_nxt = st_r;
        oidx_nxt = oidx_r;
        pidx_nxt = pidx_r;
        ord_wait_nxt = ord_wait_r;
        susp_nxt = susp_r;
        issued_nxt = issued_r;
        osrc_prev_nxt = ovalid && osrc;
        psrc_prev_nxt = pvalid && psrc;

        if (rd) begin
            case (paddr)
                `OFS_CTRL: prdata_nxt = ctrl_r;
                `OFS_ORD_SEQ: prdata_nxt = oseq_r;
                `OFS_PRE_SEQ: prdata_nxt = pseq_r;
                `OFS_ORD_RESULT: prdata_nxt = {20'h0_0000, ores_r};
                `OFS_PRE_RESULT: prdata_nxt = {20'h0_0000, pres_r};
                `OFS_STATUS: prdata_nxt = {27'h000_0000, cal_busy, st_r == ST_PRE,
                                           st_r == ST_ORD || susp_r, pend_flag_r, oend_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end

        // Status flags clear on writing one; a same-cycle set below wins.
        if (wr && paddr == `OFS_STATUS) begin
            if (pwdata[`ST_ORD_END]) begin
                oend_nxt = 1'b0;
            end
            if (pwdata[`ST_PRE_END]) begin
                pend_flag_nxt = 1'b0;
            end
        end
        if (wr && paddr == `OFS_ORD_SEQ) begin
            oseq_nxt = pwdata;
        end
        if (wr && paddr == `OFS_PRE_SEQ) begin
            pseq_nxt = pwdata;
        end
        if (wr_ctrl) begin
            ctrl_nxt = pwdata;
            ctrl_nxt[`CTRL_ORD_SWT] = 1'b0;
            ctrl_nxt[`CTRL_PRE_SWT] = 1'b0;
            ctrl_nxt[`CTRL_CAL] = cal_busy || (pwdata[`CTRL_CAL] && pwdata[`CTRL_POWER]);
        end

        case (st_r)
            ST_OFF: begin
                if (ctrl_r[`CTRL_POWER]) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                issued_nxt = 1'b0;
                if (cal_busy) begin
                    st_nxt = ST_CAL;
                end else if (p_go) begin
                    st_nxt = ST_PRE;
                    pidx_nxt = '0;
                    ord_wait_nxt = ord_wait_r || o_go;
                end else if (o_go || ord_wait_r) begin
                    st_nxt = ST_ORD;
                    oidx_nxt = '0;
                    ord_wait_nxt = 1'b0;
                end
            end
            ST_CAL: begin
                if (!issued_r) begin
                    issued_nxt = 1'b1;
                end else if (conv_rsp.done) begin
                    issued_nxt = 1'b0;
                    ores_nxt = conv_rsp.data; // R12 R13
                    coeff_nxt = conv_rsp.data; // R12
                    ctrl_nxt[`CTRL_CAL] = 1'b0; // R11
                    st_nxt = ST_IDLE;
                end
            end
            ST_ORD: begin
                if (p_go) begin
                    // The slot in flight is dropped and reconverted afterwards.
                    st_nxt = ST_PRE; // R4
                    susp_nxt = 1'b1; // R4
                    pidx_nxt = '0;
                    issued_nxt = 1'b0;
                end else if (!issued_r) begin
                    issued_nxt = 1'b1;
                end else if (conv_rsp.done) begin
                    issued_nxt = 1'b0;
                    ores_nxt = conv_rsp.data;
                    oend_nxt = 1'b1;
                    dma_nxt = ctrl_r[`CTRL_DMA_EN] && (CONV_INDEX != 1); // R21
                    oidx_nxt = oidx_r + 1'b1;
                    if (o_last) begin
                        oidx_nxt = '0;
                        st_nxt = ST_IDLE;
                    end
                end
            end
            ST_PRE: begin
                if (o_go) begin
                    ord_wait_nxt = 1'b1; // R5
                end
                if (!issued_r) begin
                    issued_nxt = 1'b1;
                end else if (conv_rsp.done) begin
                    issued_nxt = 1'b0;
                    pres_nxt = conv_rsp.data;
                    pidx_nxt = pidx_r + 1'b1;
                    if (p_last) begin
                        pidx_nxt = '0;
                        pend_flag_nxt = 1'b1;
                        if (susp_r) begin
                            st_nxt = ST_ORD; // R4
                            susp_nxt = 1'b0;
                        end else if (ord_wait_r || o_go) begin
                            st_nxt = ST_ORD; // R5
                            oidx_nxt = '0;
                            ord_wait_nxt = 1'b0;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
            end
            default: st_nxt = ST_OFF;
        endcase

        // Power removal wins over everything and returns the logic to rest.
        if (wr_ctrl && !pwdata[`CTRL_POWER]) begin // R10
            st_nxt = ST_OFF;
            oidx_nxt = '0;
            pidx_nxt = '0;
            ord_wait_nxt = 1'b0;
            susp_nxt = 1'b0;
            issued_nxt = 1'b0;
            dma_nxt = 1'b0;
            ctrl_nxt[`CTRL_CAL] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RESET;
            oseq_r <= `SEQ_RESET;
            pseq_r <= `SEQ_RESET;
            ores_r <= 12'h000;
            pres_r <= 12'h000;
            oend_r <= 1'b0;
            pend_flag_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            coeff_r <= 12'h000;
            dma_r <= 1'b0;
            st_r <= ST_OFF;
            oidx_r <= '0;
            pidx_r <= '0;
            ord_wait_r <= 1'b0;
            susp_r <= 1'b0;
            issued_r <= 1'b0;
            osrc_prev_r <= 1'b0;
            psrc_prev_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            oseq_r <= oseq_nxt;
            pseq_r <= pseq_nxt;
            ores_r <= ores_nxt;
            pres_r <= pres_nxt;
            oend_r <= oend_nxt;
            pend_flag_r <= pend_flag_nxt;
            prdata_r <= prdata_nxt;
            coeff_r <= coeff_nxt;
            dma_r <= dma_nxt;
            st_r <= st_nxt;
            oidx_r <= oidx_nxt;
            pidx_r <= pidx_nxt;
            ord_wait_r <= ord_wait_nxt;
            susp_r <= susp_nxt;
            issued_r <= issued_nxt;
            osrc_prev_r <= osrc_prev_nxt;
            psrc_prev_r <= psrc_prev_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cal_clears_bit_a: assert property ( // R11
        st_r == ST_CAL && issued_r && conv_rsp.done && !wr_ctrl |=> !cal_busy && st_r == ST_IDLE)
        else $error("calibration bit not cleared");
    cal_result_a: assert property ( // R12
        st_r == ST_CAL && issued_r && conv_rsp.done |=>
        coeff_r == $past(conv_rsp.data) && ores_r == $past(conv_rsp.data))
        else $error("calibration result not stored");
    cal_no_flag_a: assert property ( // R13
        st_r == ST_CAL && issued_r && conv_rsp.done && !oend_r |=> !oend_r && !dma_req)
        else $error("calibration raised end flag or dma");
    power_off_a: assert property ( // R10
        wr_ctrl && !pwdata[`CTRL_POWER] |=> st_r == ST_OFF && !conv_req.power_on && !cal_busy)
        else $error("power clear did not reset");
    preempt_a: assert property ( // R4
        st_r == ST_ORD && p_go && !(wr_ctrl && !pwdata[`CTRL_POWER]) |=> st_r == ST_PRE && susp_r)
        else $error("preempted trigger did not suspend");
    resume_a: assert property ( // R4
        st_r == ST_PRE && susp_r && issued_r && conv_rsp.done && p_last && !wr_ctrl
        |=> st_r == ST_ORD && oidx_r == $past(oidx_r))
        else $error("ordinary group not resumed");
    ord_holds_a: assert property ( // R5
        st_r == ST_PRE && o_go && !(issued_r && conv_rsp.done && p_last) && !wr_ctrl
        |=> st_r == ST_PRE && ord_wait_r)
        else $error("ordinary trigger not held off");
    reserved_quiet_a: assert property ( // R22
        osel >= `SEL_RSV_LO && osel <= `SEL_RSV_HI |-> !o_hw_rise)
        else $error("reserved code triggered");
    second_no_dma_a: assert property ( // R21
        CONV_INDEX == 1 |-> !dma_req)
        else $error("second converter raised dma");
    edge_only_a: assert property ( // R14
        osrc_prev_r && osrc && ovalid |-> !o_hw_rise)
        else $error("level started ordinary conversion");

    preempt_c: cover property (st_r == ST_ORD && p_go ##1 st_r == ST_PRE);
    resume_c: cover property (st_r == ST_PRE && susp_r ##[1:200] st_r == ST_ORD);
    cal_c: cover property (st_r == ST_CAL ##[1:200] st_r == ST_IDLE);
    retrigger_c: cover property (wr_ctrl && pwdata[`CTRL_POWER] && ctrl_r[`CTRL_POWER]);

endmodule // conv_ctrl

`default_nettype wire

//--- verification/conv_analog_model.sv
// Behavioural model of the analog converter that answers the control block.
`timescale 1ns/1ps
`default_nettype none

module conv_analog_model
    import conv_ctrl_pkg::*;
#(
    parameter logic [11:0] CAL_VALUE = 12'h05A3
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Converter side of the control block.
    input wire conv_req_t conv_req,
    output conv_rsp_t conv_rsp,
    // Answer delay in cycles after a start, set by the bench.
    input wire logic [3:0] delay
);
    logic busy_r;
    logic cal_r;
    logic [3:0] cnt_r;
    logic [11:0] val_r;
    logic [11:0] last_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            cal_r <= 1'b0;
            cnt_r <= 4'h0;
            val_r <= 12'h000;
            last_r <= 12'h000;
        end else if (!conv_req.power_on) begin
            busy_r <= 1'b0;
        end else if (conv_req.start || conv_req.calibrate) begin
            busy_r <= 1'b1;
            cal_r <= conv_req.calibrate;
            cnt_r <= delay;
            val_r <= conv_req.grounded ? 12'h000 : {conv_req.channel, 7'h2B};
        end else if (conv_req.abort) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                last_r <= conv_rsp.data;
            end
        end
    end

    // Between answers the data lines show the inverse of the last answer.
    assign conv_rsp.done = busy_r && (cnt_r == 4'h0);
    assign conv_rsp.data = !conv_rsp.done ? ~last_r : (cal_r ? CAL_VALUE : val_r);
endmodule // conv_analog_model

`default_nettype wire

//--- verification/adc_channel_trigger_control_tb_top.sv
// Self-checking bench for the converter control block with its analog model.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.svh"

module adc_channel_trigger_control_tb_top
    import conv_ctrl_pkg::*;
;
    localparam logic [11:0] CAL_VALUE = 12'h05A3;
    // Power, sensor, both trigger enables and DMA; the calibration writes before it leave the sensor off.
    localparam logic [31:0] BASE = 32'h0000_009D;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dma_req, rd_e, dma2;
    logic [11:0] paddr, cal_coeff;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] conv_delay;
    trig_in_t ord_trig, pre_trig;
    conv_req_t conv_req, req2;
    conv_rsp_t conv_rsp;
    int err_count, tests_run, starts, aborts, dmas, cycles, dmas2;
    int ch_q[$];
    int gnd_q[$];
    int rc[$];

    conv_ctrl #(.CONV_INDEX(0), .SLOTS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ord_trig(ord_trig), .pre_trig(pre_trig),
        .conv_req(conv_req), .conv_rsp(conv_rsp), .cal_coeff(cal_coeff), .dma_req(dma_req));
    conv_analog_model #(.CAL_VALUE(CAL_VALUE)) model (.pclk(pclk), .presetn(presetn),
        .conv_req(conv_req), .conv_rsp(conv_rsp), .delay(conv_delay));
    // A second-converter copy runs in lockstep on the same bus and answers.
    conv_ctrl #(.CONV_INDEX(1), .SLOTS(4)) dut2 (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .ord_trig(ord_trig), .pre_trig(pre_trig),
        .conv_req(req2), .conv_rsp(conv_rsp), .cal_coeff(), .dma_req(dma2));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (conv_req.start === 1'b1) begin
            starts++;
            ch_q.push_back(int'(conv_req.channel));
            gnd_q.push_back(int'(conv_req.grounded));
        end
        if (conv_req.abort === 1'b1) aborts++;
        if (dma_req === 1'b1) dmas++;
        if (dma2 === 1'b1) dmas2++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic waitz(input logic [11:0] a, input logic [31:0] m);
        int n;
        n = 0;
        tick(2);
        apb(1'b0, a, 32'h0);
        while ((rd_q & m) !== 32'h0 && n < 300) begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        chk("wait bound", n < 300, 1);
        tick(2);
    endtask

    task automatic flush();
        ch_q.delete();
        gnd_q.delete();
        starts = 0;
        aborts = 0;
        dmas = 0;
    endtask

    // Every control write with power kept on also retriggers the ordinary group.
    task automatic cfg(input logic [31:0] v);
        apb(1'b1, `OFS_CTRL, v);
        waitz(`OFS_STATUS, 32'h0000_001C);
        apb(1'b1, `OFS_STATUS, 32'h0000_0003);
        flush();
    endtask

    function automatic logic [31:0] seq(input int a, b, c, d, n);
        return {9'h0, 3'(n - 1), 20'((d << 15) | (c << 10) | (b << 5) | a)};
    endfunction

    function automatic logic [11:0] dat(input int c);
        return (c > 17) ? 12'h000 : {5'(c), 7'h2B};
    endfunction

    task automatic seqchk(input int e[$]);
        chk("start count", ch_q.size(), e.size());
        foreach (e[i]) if (i < ch_q.size()) chk("start channel", ch_q[i], e[i]);
        foreach (ch_q[i]) chk("grounded", gnd_q[i], ch_q[i] > 17);
    endtask

    task automatic hw(input logic [3:0] code, input logic mux, input logic [15:0] evt,
                      input logic ext, input int exp);
        cfg(BASE | ({28'h0, code} << `CTRL_ORD_SEL_LSB) | ({31'h0, mux} << `CTRL_ORD_MUX));
        ord_trig <= '{timer_evt: evt, ext_line: ext};
        tick(12);
        waitz(`OFS_STATUS, 32'h0000_001C);
        chk("hw trigger starts", starts, exp);
        ord_trig <= '0;
        @(posedge pclk);
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ord_trig = '0;
        pre_trig = '0;
        conv_delay = 4'h2;
        presetn = 1'b0;
        void'($urandom(71290));
        tick(5);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl reset", rd_q, `CTRL_RESET);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", rd_e, 1);
        chk("unmapped data", rd_q, 32'h0);
        $display("test reset done");
        conv_delay <= 4'hF;
        apb(1'b1, `OFS_CTRL, 32'h0000_0081);
        tick(20);
        // The calibration write rewrites power too, so one ordinary conversion runs first.
        apb(1'b1, `OFS_CTRL, 32'h0000_0083);
        waitz(`OFS_STATUS, 32'h0000_0004);
        apb(1'b1, `OFS_STATUS, 32'h0000_0003);
        flush();
        waitz(`OFS_CTRL, 32'h0000_0002);
        apb(1'b0, `OFS_ORD_RESULT, 32'h0);
        chk("calibration result", rd_q, {20'h0, CAL_VALUE});
        chk("calibration coefficient", cal_coeff, {20'h0, CAL_VALUE});
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("calibration end flag", rd_q[0], 0);
        chk("calibration dma", dmas, 0);
        $display("test calibration done");
        for (int i = 0; i < 4; i++) rc.push_back($urandom_range(31, 0));
        apb(1'b1, `OFS_ORD_SEQ, seq(rc[0], rc[1], rc[2], rc[3], 4));
        conv_delay <= 4'($urandom_range(8, 1));
        cfg(BASE & ~32'h0000_0008);
        apb(1'b1, `OFS_CTRL, BASE & ~32'h0000_0008);
        waitz(`OFS_STATUS, 32'h0000_001C);
        seqchk(rc);
        apb(1'b0, `OFS_ORD_RESULT, 32'h0);
        chk("ordinary result", rd_q, {20'h0, dat(rc[3])});
        chk("dma pulses", dmas, 4);
        chk("second converter dma", dmas2, 0);
        chk("sensor enable", conv_req.sensor_on, 1);
        chk("second sensor enable", req2.sensor_on, 0);
        $display("test retrigger sequence done");
        conv_delay <= 4'h2;
        apb(1'b1, `OFS_ORD_SEQ, seq(5, 5, 5, 5, 1));
        for (int c = 0; c < 16; c++) hw(4'(c), 1'b0, 16'h0001 << c, 1'b0, (c < 6 || c > 12));
        hw(4'h6, 1'b0, 16'h0000, 1'b1, 1);
        hw(4'h6, 1'b1, 16'h0000, 1'b1, 0);
        hw(4'h6, 1'b1, 16'h0040, 1'b0, 1);
        $display("test trigger select done");
        conv_delay <= 4'hA;
        apb(1'b1, `OFS_ORD_SEQ, seq(1, 2, 1, 2, 2));
        apb(1'b1, `OFS_PRE_SEQ, seq(9, 9, 9, 9, 1));
        cfg(BASE | 32'h0000_7000);
        apb(1'b1, `OFS_CTRL, BASE | 32'h0000_7040);
        waitz(`OFS_STATUS, 32'h0000_001C);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("preempted end", rd_q[1], 1);
        apb(1'b0, `OFS_PRE_RESULT, 32'h0);
        chk("preempted result", rd_q, {20'h0, dat(9)});
        $display("test preempted software trigger done");
        cfg(BASE);
        apb(1'b1, `OFS_CTRL, BASE);
        tick(3);
        pre_trig <= '{timer_evt: 16'h0001, ext_line: 1'b0};
        waitz(`OFS_STATUS, 32'h0000_001C);
        pre_trig <= '0;
        tick(1);
        seqchk('{1, 9, 1, 2});
        chk("suspend aborts", aborts, 1);
        flush();
        pre_trig <= '{timer_evt: 16'h0001, ext_line: 1'b0};
        tick(3);
        ord_trig <= '{timer_evt: 16'h0001, ext_line: 1'b0};
        waitz(`OFS_STATUS, 32'h0000_001C);
        pre_trig <= '0;
        ord_trig <= '0;
        seqchk('{9, 1, 2});
        chk("hold-off aborts", aborts, 0);
        $display("test group priority done");
        flush();
        apb(1'b1, `OFS_CTRL, BASE);
        tick(2);
        apb(1'b1, `OFS_CTRL, 32'h0);
        tick(2);
        chk("power-off abort", aborts, 1);
        chk("analog power", conv_req.power_on, 0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("busy after power-off", rd_q & 32'h0000_001C, 0);
        $display("test power-off done");
        end_of_test();
    end
endmodule // adc_channel_trigger_control_tb_top

`default_nettype wire
